// ---- asc_pkg.sv ----
// Purpose: constants, register map and carrier types of the serial controller
// Assumes: one 10 MHz clock, plain register port with one-cycle read latency
// Notes:   register offsets and field positions are local choices
package asc_pkg;
   // ==========================================================
   // register offsets
   localparam logic [4:0] ADDR_RX_DATA    = 5'h00;
   localparam logic [4:0] ADDR_TX_DATA    = 5'h01;
   localparam logic [4:0] ADDR_IEN        = 5'h02;
   localparam logic [4:0] ADDR_IIDENT     = 5'h03;
   localparam logic [4:0] ADDR_LSTAT      = 5'h04;
   localparam logic [4:0] ADDR_RSTAT      = 5'h05;
   localparam logic [4:0] ADDR_MSTAT      = 5'h06;
   localparam logic [4:0] ADDR_TSTAT      = 5'h07;
   localparam logic [4:0] ADDR_ICMD       = 5'h08;
   localparam logic [4:0] ADDR_RCMD       = 5'h09;
   localparam logic [4:0] ADDR_TMODE      = 5'h0A;
   localparam logic [4:0] ADDR_RMODE      = 5'h0B;
   localparam logic [4:0] ADDR_CLKCFG     = 5'h0C;
   localparam logic [4:0] ADDR_PINMODE    = 5'h0D;
   localparam logic [4:0] ADDR_ACMP_A     = 5'h0E;
   localparam logic [4:0] ADDR_ACMP_B     = 5'h0F;
   localparam logic [4:0] ADDR_LEVEL      = 5'h10;
   localparam logic [4:0] ADDR_DIVISOR    = 5'h11;
   localparam logic [4:0] ADDR_EVT_STAT   = 5'h12;
   localparam logic [4:0] ADDR_EVT_CLR    = 5'h13;
   localparam logic [4:0] ADDR_EVT_EN     = 5'h14;
   // ==========================================================
   // command and mode encodings
   localparam int         ICMD_STATUS_CLR = 2;
   localparam int         RCMD_LOCK       = 3;
   localparam int         RCMD_FLUSH_BUF  = 4;
   localparam int         RCMD_FLUSH_MACH = 5;
   localparam int         RCMD_ENABLE     = 7;
   localparam logic [7:0] CLKCFG_EXT_TX   = 8'h30;
   localparam int         CLKCFG_DIV2     = 0;
   localparam int         PINMODE_SCLK    = 0;
   localparam logic [1:0] TMODE_MANUAL    = 2'h0;
   localparam logic [1:0] TMODE_SEMI      = 2'h1;
   localparam logic [1:0] TMODE_AUTO      = 2'h2;
   localparam int         TMODE_RTS_BIT   = 2;
   localparam logic [1:0] RMODE_NORMAL    = 2'h0;
   localparam logic [1:0] RMODE_SEMI      = 2'h1;
   localparam logic [1:0] RMODE_AUTO      = 2'h2;
   localparam int         RMODE_AUTOACK   = 2;
   localparam int         IEN_TX_BIT      = 1;
   localparam int         IEN_RX_BIT      = 0;
   localparam int         LSTAT_RX_BIT    = 0;
   localparam int         LSTAT_OVR_BIT   = 1;
   localparam int         LSTAT_FRM_BIT   = 2;
   localparam int         LSTAT_TXE_BIT   = 4;
   // ==========================================================
   // sizes and reset values
   localparam int         BUF_DEPTH       = 4;
   localparam int         OVERSAMPLE      = 16;
   localparam logic [7:0] DIVISOR_RST     = 8'h01;
   localparam logic [7:0] ZERO8           = 8'h00;
   localparam int         EVT_RX          = 0;
   localparam int         EVT_TX          = 1;
   localparam int         EVT_ERR         = 2;

   // ==========================================================
   // carrier types
   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } asc_bus_type;

   typedef struct packed {
      logic       sclk;
      logic       rxd;
      logic       cts_n;
   } asc_line_in_type;
endpackage : asc_pkg

// ---- asc_top.sv ----
// Purpose: asynchronous serial controller with corrected status and buffer behaviour
// Assumes: all inputs synchronous to core_clk_i; host strobes framed by chip select
// Notes:   eight data bits, one stop bit, no parity; 16x oversampling
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module asc_top
   import asc_pkg::*;
(
   // clock, reset, enable
   input  wire logic            core_clk_i,
   input  wire logic            nrst_i,
   input  wire logic            clk_en_i,
   // register port
   input  wire logic            cs_i,
   input  wire asc_bus_type     bus_i,
   output      logic [7:0]      rdata_o,
   // serial line
   input  wire asc_line_in_type line_i,
   output      logic            txd_o,
   output      logic            rts_n_o,
   // interrupts
   output      logic            irq_o,
   output      logic            evt_irq_o
);
   // ==========================================================
   // registers
   logic [7:0] rbuf [BUF_DEPTH];
   logic [1:0] wptr, rptr;
   logic [2:0] level;
   logic       locked, rx_en, rx_open;
   logic [7:0] ien, lstat, rstat, mstat, tstat, tmode, rmode, clkcfg, pinmode;
   logic [7:0] acmp_a, acmp_b, divisor, evt_stat, evt_en;
   logic       tx_hold;
   logic [7:0] tx_data;
   logic       tx_pend;
   logic       div2_ph;
   logic [7:0] bdiv;
   logic       sclk_d;
   // ==========================================================
   // bus decode; strobes only count inside chip select
   wire        wr   = bus_i.wr & cs_i;
   wire        rd   = bus_i.rd & cs_i;
   function automatic logic hit(input logic s, input logic [4:0] a);
      hit = s & (bus_i.addr == a);
   endfunction : hit
   wire        wr_tx    = hit(wr, ADDR_TX_DATA);
   wire        wr_lstat = hit(wr, ADDR_LSTAT);
   wire        wr_icmd  = hit(wr, ADDR_ICMD);
   wire        wr_rcmd  = hit(wr, ADDR_RCMD);
   wire        rd_rx    = hit(rd, ADDR_RX_DATA);
   wire        rd_ident = hit(rd, ADDR_IIDENT);
   wire        rd_rstat = hit(rd, ADDR_RSTAT);
   wire        stat_clr = wr_icmd & bus_i.wdata[ICMD_STATUS_CLR];
   // one write of xB8 fires all four receive commands at once
   wire        c_en     = wr_rcmd & bus_i.wdata[RCMD_ENABLE];
   wire        c_fmach  = wr_rcmd & bus_i.wdata[RCMD_FLUSH_MACH];
   wire        c_fbuf   = wr_rcmd & bus_i.wdata[RCMD_FLUSH_BUF];
   wire        c_lock   = wr_rcmd & bus_i.wdata[RCMD_LOCK];
   wire        lvl_zero = wr_lstat & ~bus_i.wdata[LSTAT_RX_BIT];
   wire        buf_clr  = c_fbuf | lvl_zero;
   // ==========================================================
   // baud tick: input divide, optional external clock for the transmitter only
   wire        div2     = clkcfg[CLKCFG_DIV2];
   wire        in_tick  = ~div2 | div2_ph;
   wire        b16      = in_tick & (bdiv == 8'h00);
   wire        ext_tx   = (clkcfg == CLKCFG_EXT_TX) & pinmode[PINMODE_SCLK];
   wire        sclk_rise = line_i.sclk & ~sclk_d;
   wire        tx_tick16 = ext_tx ? sclk_rise : b16;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         div2_ph <= 1'b0;
         bdiv    <= 8'h00;
         sclk_d  <= 1'b0;
      end else if (clk_en_i) begin
         div2_ph <= ~div2_ph;
         sclk_d  <= line_i.sclk;
         if (in_tick) bdiv <= (bdiv == 8'h00) ? divisor - 8'h01 : bdiv - 8'h01;
      end
   end
   // ==========================================================
   // receiver: 16x sampling, rearm at mid stop bit
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asc_rx_type;
   asc_rx_type rxs;
   logic [3:0] rx_os;
   logic [2:0] rx_bit;
   logic [7:0] rx_sh;
   logic       rx_9th;
   logic       rx_done, rx_ferr;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rxs <= RX_IDLE; rx_os <= 4'h0; rx_bit <= 3'h0; rx_sh <= ZERO8;
         rx_done <= 1'b0; rx_ferr <= 1'b0; rx_9th <= 1'b0;
      end else if (clk_en_i) begin
         rx_done <= 1'b0;
         if (c_fmach) rxs <= RX_IDLE;
         else if (b16 && rx_en) begin
            rx_os <= rx_os + 4'h1;
            case (rxs)
               RX_IDLE:  if (!line_i.rxd) begin rxs <= RX_START; rx_os <= 4'h1; end
               RX_START: if (rx_os == 4'h7) begin
                  rxs <= line_i.rxd ? RX_IDLE : RX_DATA; rx_os <= 4'h0; rx_bit <= 3'h0;
               end
               RX_DATA:  if (rx_os == 4'hF) begin
                  rx_sh <= {line_i.rxd, rx_sh[7:1]};
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h7) rxs <= RX_STOP;
               end
               // stop judged at its centre, back to idle at once so a start
               // that trims the stop bit short is still caught
               RX_STOP:  if (rx_os == 4'hF) begin
                  rxs <= RX_IDLE; rx_done <= 1'b1; rx_ferr <= ~line_i.rxd;
                  rx_9th <= (rmode[1:0] != RMODE_NORMAL) & rx_sh[7];
               end
               default:  rxs <= RX_IDLE;
            endcase
         end
      end
   end
   // ==========================================================
   // address gating of the receive buffer
   wire        is_addr  = rx_done & rx_9th;
   wire        addr_hit = (rx_sh == acmp_a) | (rx_sh == acmp_b);
   wire        mode_semi = rmode[1:0] == RMODE_SEMI;
   wire        mode_auto = rmode[1:0] == RMODE_AUTO;
   wire        next_open = mode_semi ? 1'b1 : (mode_auto ? addr_hit : rx_open);
   wire        rx_open_now = (rmode[1:0] == RMODE_NORMAL) | (is_addr ? next_open : rx_open);
   wire        store    = rx_done & rx_open_now & ~locked & (level != 3'(BUF_DEPTH));
   wire        ovr      = rx_done & rx_open_now & ~locked & (level == 3'(BUF_DEPTH));
   wire        pop      = rd_rx & (level != 3'h0);
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         wptr <= 2'h0; rptr <= 2'h0; level <= 3'h0; rx_open <= 1'b0;
      end else if (clk_en_i) begin
         if (is_addr) rx_open <= next_open;
         if (buf_clr) begin
            wptr <= 2'h0; rptr <= 2'h0; level <= 3'h0;
         end else begin
            if (store) wptr <= wptr + 2'h1;
            if (pop)   rptr <= rptr + 2'h1;
            level <= level + {2'b00, store} - {2'b00, pop};
         end
      end
   end
   generate
      for (genvar g = 0; g < BUF_DEPTH; g++) begin : g_buf
         always_ff @(posedge core_clk_i) begin
            if (!nrst_i) rbuf[g] <= ZERO8;
            else if (clk_en_i && store && wptr == 2'(g)) rbuf[g] <= rx_sh;
         end
      end
   endgenerate
   // ==========================================================
   // receive command register: flush machine unlocks and beats lock
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         rx_en <= 1'b0; locked <= 1'b0;
      end else if (clk_en_i) begin
         if (c_en) rx_en <= 1'b1;
         if (c_fmach) locked <= 1'b0;
         else if (c_lock) locked <= 1'b1;
      end
   end
   // ==========================================================
   // transmitter; automatic modes lead with one bit of RTS
   typedef enum logic [2:0] {TX_IDLE, TX_LEAD, TX_START, TX_DATA, TX_STOP} asc_tx_type;
   asc_tx_type txs;
   logic [3:0] tx_os;
   logic [2:0] tx_bit;
   logic [7:0] tx_sh;
   logic       auto_rts;
   logic       tx_done;
   wire        tx_auto  = (tmode[1:0] == TMODE_SEMI) | (tmode[1:0] == TMODE_AUTO);
   wire        tx_bit_end = tx_tick16 & (tx_os == 4'hF);
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         txs <= TX_IDLE; tx_os <= 4'h0; tx_bit <= 3'h0; tx_sh <= ZERO8;
         txd_o <= 1'b1; auto_rts <= 1'b0; tx_pend <= 1'b0; tx_data <= ZERO8;
         tx_done <= 1'b0;
      end else if (clk_en_i) begin
         tx_done <= 1'b0;
         if (wr_tx) begin tx_data <= bus_i.wdata; tx_pend <= 1'b1; end
         if (tx_tick16) tx_os <= tx_os + 4'h1;
         case (txs)
            TX_IDLE: if (tx_pend && !wr_tx) begin
               tx_sh <= tx_data; tx_pend <= 1'b0; tx_os <= 4'h0;
               if (tx_auto && !auto_rts) begin
                  txs <= TX_LEAD; auto_rts <= 1'b1;
               end else txs <= TX_START;
            end else if (!tx_pend) auto_rts <= 1'b0;
            TX_LEAD:  if (tx_bit_end) txs <= TX_START;
            TX_START: begin
               txd_o <= 1'b0;
               if (tx_bit_end) begin txs <= TX_DATA; tx_bit <= 3'h0; end
            end
            TX_DATA: begin
               txd_o <= tx_sh[tx_bit];
               if (tx_bit_end) begin
                  tx_bit <= tx_bit + 3'h1;
                  if (tx_bit == 3'h7) txs <= TX_STOP;
               end
            end
            TX_STOP: begin
               txd_o <= 1'b1;
               if (tx_bit_end) begin txs <= TX_IDLE; tx_done <= 1'b1; end
            end
            default: txs <= TX_IDLE;
         endcase
      end
   end
   // automatic modes take request-to-send from the machine
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) rts_n_o <= 1'b1;
      else if (clk_en_i) rts_n_o <= tx_auto ? ~auto_rts : ~tmode[TMODE_RTS_BIT];
   end
   // ==========================================================
   // status registers; hardware set wins over any clear
   wire [7:0] rstat_set = {5'h00, rx_ferr & rx_done, ovr, level != 3'h0};
   wire [7:0] lstat_set = {3'h0, txs == TX_IDLE, 1'b0, rx_ferr & rx_done, ovr, 1'b0};
   wire [7:0] keep0     = 8'h01;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         lstat <= ZERO8; rstat <= ZERO8; mstat <= ZERO8; tstat <= ZERO8;
      end else if (clk_en_i) begin
         if (stat_clr) begin
            // bit 0 tracks the buffer and is left alone
            rstat <= (rstat & keep0) | rstat_set;
            lstat <= (lstat & keep0) | lstat_set;
            mstat <= ZERO8;
            tstat <= {7'h00, tx_done};
         end else begin
            if (rd_rstat) rstat <= {rstat[7:1], level != 3'h0} | rstat_set;
            else rstat <= rstat | rstat_set;
            if (wr_lstat) lstat <= {lstat[7:5], bus_i.wdata[4:0]} | lstat_set;
            else lstat <= lstat | lstat_set;
            mstat <= {mstat[7:1], mstat[0] | (line_i.cts_n != rts_n_o & 1'b0)};
            tstat <= tstat | {7'h00, tx_done};
         end
         if (!(wr_lstat || stat_clr)) lstat[LSTAT_RX_BIT] <= level != 3'h0;
      end
   end
   // ==========================================================
   // control registers and transmit hold
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         ien <= ZERO8; tmode <= ZERO8; rmode <= ZERO8; clkcfg <= ZERO8; pinmode <= ZERO8;
         acmp_a <= ZERO8; acmp_b <= ZERO8; divisor <= DIVISOR_RST; tx_hold <= 1'b0;
      end else if (clk_en_i) begin
         if (hit(wr, ADDR_IEN))     ien     <= bus_i.wdata;
         if (hit(wr, ADDR_TMODE))   tmode   <= bus_i.wdata;
         if (hit(wr, ADDR_RMODE))   rmode   <= bus_i.wdata;
         if (hit(wr, ADDR_CLKCFG))  clkcfg  <= bus_i.wdata;
         if (hit(wr, ADDR_PINMODE)) pinmode <= bus_i.wdata;
         if (hit(wr, ADDR_ACMP_A))  acmp_a  <= bus_i.wdata;
         if (hit(wr, ADDR_ACMP_B))  acmp_b  <= bus_i.wdata;
         if (hit(wr, ADDR_DIVISOR)) divisor <= (bus_i.wdata == 8'h00) ? 8'h01 : bus_i.wdata;
         if (wr_tx || !ien[IEN_TX_BIT]) tx_hold <= 1'b0;
         else if (rd_ident) tx_hold <= 1'b1;
      end
   end
   // ==========================================================
   // device interrupt: receive data pending and not acknowledged, or transmit empty not held
   logic rx_ack;
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) rx_ack <= 1'b0;
      else if (clk_en_i) begin
         if (store) rx_ack <= 1'b0;
         else if ((rd_rx && rmode[RMODE_AUTOACK]) || rd_rstat) rx_ack <= 1'b1;
      end
   end
   wire rx_irq = ien[IEN_RX_BIT] & (level != 3'h0) & ~rx_ack;
   wire tx_irq = ien[IEN_TX_BIT] & ~tx_pend & (txs == TX_IDLE) & ~tx_hold;
   assign irq_o = rx_irq | tx_irq;
   // ==========================================================
   // event interrupt block
   wire [2:0] evt_set = {rx_done & (rx_ferr | ovr), tx_done, store};
   wire       evt_clr_w = hit(wr, ADDR_EVT_CLR);
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) begin
         evt_stat <= ZERO8; evt_en <= ZERO8;
      end else if (clk_en_i) begin
         if (hit(wr, ADDR_EVT_EN)) evt_en <= bus_i.wdata;
         evt_stat <= (evt_stat & ~(evt_clr_w ? bus_i.wdata : ZERO8)) | {5'h00, evt_set};
      end
   end
   assign evt_irq_o = |(evt_stat & evt_en);
   // ==========================================================
   // read data mux, registered
   logic [7:0] rsel;
   always_comb begin
      case (bus_i.addr)
         ADDR_RX_DATA:  rsel = rbuf[rptr];
         ADDR_IEN:      rsel = ien;
         ADDR_IIDENT:   rsel = {6'h00, tx_irq, rx_irq};
         ADDR_LSTAT:    rsel = lstat;
         ADDR_RSTAT:    rsel = rstat;
         ADDR_MSTAT:    rsel = mstat;
         ADDR_TSTAT:    rsel = tstat;
         ADDR_TMODE:    rsel = tmode;
         ADDR_RMODE:    rsel = rmode;
         ADDR_CLKCFG:   rsel = clkcfg;
         ADDR_PINMODE:  rsel = pinmode;
         ADDR_ACMP_A:   rsel = acmp_a;
         ADDR_ACMP_B:   rsel = acmp_b;
         ADDR_LEVEL:    rsel = {5'h00, level};
         ADDR_DIVISOR:  rsel = divisor;
         ADDR_EVT_STAT: rsel = evt_stat;
         ADDR_EVT_EN:   rsel = evt_en;
         default:       rsel = ZERO8;
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (!nrst_i) rdata_o <= ZERO8;
      else if (clk_en_i) rdata_o <= rd ? rsel : ZERO8;
   end
endmodule : asc_top

// ---- asc_modem.sv ----
// Purpose: behavioural modem on the serial side of the controller
// Assumes: bit time given in core clock cycles
// Notes:   serial clock stands still unless enabled
`timescale 1ns/1ps
module asc_modem #(
   parameter int BIT_CYC = 16
) (
   // clock
   input  wire logic core_clk_i,
   // serial clock enable
   input  wire logic sclk_on_i,
   // line outputs
   output      logic rxd_o,
   output      logic sclk_o
);
   // ==========================================================
   // line state
   // idle line is high, clock parked low between uses
   initial begin
      rxd_o = 1'b1;
      sclk_o = 1'b0;
   end
   always @(posedge core_clk_i) begin
      sclk_o <= sclk_on_i ? !sclk_o : 1'b0;
   end
   // ==========================================================
   // frame sender
   // 8N1 lsb first; a short stop lets the next start come early
   task automatic send(input logic [7:0] v, input int stop_cyc);
      logic [9:0] frame;
      frame = {1'b1, v, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd_o <= frame[i];
         repeat ((i == 9) ? stop_cyc : BIT_CYC) @(posedge core_clk_i);
      end
   endtask : send
endmodule : asc_modem

// ---- asc_top_assertions.sv ----
// Purpose: port-level checks of the serial controller
// Assumes: divisor at reset value, internal transmit clock for timing checks
// Notes:   bound into every asc_top instance
`timescale 1ns/1ps
module asc_top_assertions
   import asc_pkg::*;
(
   // clock, reset, enable
   input wire logic            core_clk_i,
   input wire logic            nrst_i,
   input wire logic            clk_en_i,
   // register port
   input wire logic            cs_i,
   input wire asc_bus_type     bus_i,
   input wire logic [7:0]      rdata_o,
   // serial line and interrupts
   input wire asc_line_in_type line_i,
   input wire logic            txd_o,
   input wire logic            rts_n_o,
   input wire logic            irq_o,
   input wire logic            evt_irq_o
);
   // ==========================================================
   // one clock domain
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   // read data only in the answer cycle of a taken read
   a_rdata_idle: assert property (
      clk_en_i && !(bus_i.rd && cs_i) |=> rdata_o == 8'h00)
      else $error("read data outside its answer cycle");
   a_cs_gate: assert property (
      clk_en_i && bus_i.rd && !cs_i |=> rdata_o == 8'h00)
      else $error("read answered without chip select");
   a_unmapped_read: assert property (
      clk_en_i && bus_i.rd && cs_i && bus_i.addr > ADDR_EVT_EN |=> rdata_o == 8'h00)
      else $error("unmapped read gave data");
   // outputs idle on the first edge after reset
   a_reset_lines: assert property (
      $rose(nrst_i) |-> txd_o && rts_n_o && rdata_o == 8'h00)
      else $error("lines not idle after reset");
   a_reset_irq: assert property (
      $rose(nrst_i) |-> !irq_o && !evt_irq_o)
      else $error("interrupt high after reset");
   // a full bit of request-to-send lead before the start bit
   a_rts_lead: assert property (
      $fell(txd_o) && !rts_n_o |-> !$past(rts_n_o, 16))
      else $error("request-to-send lead too short");
   a_rts_quiet: assert property (
      $fell(rts_n_o) |-> txd_o [*8])
      else $error("start bit with request-to-send");
   a_start_width: assert property (
      $fell(txd_o) |-> !txd_o [*8])
      else $error("start bit cut short");
   // main scenarios reached
   c_tx_auto: cover property ($fell(txd_o) && !rts_n_o);
   c_irq: cover property ($rose(irq_o));
   c_evt: cover property ($rose(evt_irq_o));
endmodule : asc_top_assertions
bind asc_top asc_top_assertions u_chk (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
   .clk_en_i(clk_en_i), .cs_i(cs_i), .bus_i(bus_i), .rdata_o(rdata_o), .line_i(line_i),
   .txd_o(txd_o), .rts_n_o(rts_n_o), .irq_o(irq_o), .evt_irq_o(evt_irq_o));

// ---- asc_top_bench.sv ----
// Purpose: self-checking bench of the serial controller
// Assumes: divisor at reset value, so one bit is 16 cycles
// Notes:   register rows first, then hand-written tests
`timescale 1ns/1ps
module asc_top_bench
   import asc_pkg::*;
();
   typedef struct packed {
      logic       cs;
      logic       w;
      logic [4:0] a;
      logic [7:0] d;
   } asc_row_type;
   // d is write data on writes, expected data on reads
   localparam asc_row_type ROWS [8] = '{
      '{1'b1, 1'b0, ADDR_LEVEL, ZERO8}, '{1'b1, 1'b0, ADDR_DIVISOR, DIVISOR_RST},
      '{1'b1, 1'b1, ADDR_ACMP_A, 8'h85}, '{1'b0, 1'b1, ADDR_ACMP_A, 8'hFF},
      '{1'b1, 1'b0, ADDR_ACMP_A, 8'h85}, '{1'b0, 1'b0, ADDR_ACMP_A, ZERO8},
      '{1'b1, 1'b1, ADDR_ACMP_B, 8'hA5}, '{1'b1, 1'b0, 5'h1F, ZERO8}};
   logic            core_clk_i = 1'b0;
   logic            nrst_i = 1'b0;
   logic            cs_i = 1'b1;
   logic            sclk_on = 1'b0;
   asc_bus_type     bus = '0;
   asc_line_in_type line;
   logic [7:0]      rdata_o, d;
   logic            txd_o, rts_n_o, irq_o, evt_irq_o, m_rxd, m_sclk;
   int              fails = 0, cmp_count = 0, n;
   // ==========================================================
   // clock, line and instances
   always #50 core_clk_i = !core_clk_i;
   assign line = {m_sclk, m_rxd, 1'b1};
   asc_top u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(1'b1), .cs_i(cs_i),
      .bus_i(bus), .rdata_o(rdata_o), .line_i(line), .txd_o(txd_o), .rts_n_o(rts_n_o),
      .irq_o(irq_o), .evt_irq_o(evt_irq_o));
   asc_modem u_mod (.core_clk_i(core_clk_i), .sclk_on_i(sclk_on), .rxd_o(m_rxd),
      .sclk_o(m_sclk));
   // ==========================================================
   // tasks
   task automatic check(input string s, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask : tick
   // chip select rides with the strobe and rests high between accesses; rows with cs clear strobe without it
   task automatic acc(input logic c, input logic w, input logic [4:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      cs_i <= c;
      bus <= '{a, v, w, !w};
      @(posedge core_clk_i);
      cs_i <= 1'b1;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      #1 d = rdata_o;
   endtask : acc
   task automatic w(input logic [4:0] a, input logic [7:0] v);
      acc(1'b1, 1'b1, a, v);
   endtask : w
   task automatic rc(input string s, input logic [4:0] a, input logic [7:0] e);
      acc(1'b1, 1'b0, a, ZERO8);
      check(s, d, e);
   endtask : rc
   task automatic rx(input logic [7:0] v);
      u_mod.send(v, 16);
      tick(4);
   endtask : rx
   // waits on request-to-send, counts the lead, samples bits mid-cell
   task automatic txcap(output int lead, output logic [7:0] v);
      lead = 0;
      for (int k = 0; k < 300 && rts_n_o !== 1'b0; k++) tick(1);
      while (txd_o === 1'b1 && lead < 300) begin
         tick(1);
         lead++;
      end
      tick(8);
      for (int i = 0; i < 8; i++) begin
         tick(16);
         v[i] = txd_o;
      end
   endtask : txcap
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   // ==========================================================
   // watchdog, about five times the expected run
   initial begin
      #2000000;
      fails++;
      summarize();
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      foreach (ROWS[i]) begin
         acc(ROWS[i].cs, ROWS[i].w, ROWS[i].a, ROWS[i].d);
         if (!ROWS[i].w) check("row", d, ROWS[i].d);
      end
      $display("end of register rows");
      // event interrupt raised, cleared, masked
      w(ADDR_EVT_EN, 8'h01);
      w(ADDR_RCMD, 8'h80);
      rx(8'h3C);
      check("evt irq", {7'h0, evt_irq_o}, 8'h01);
      rc("rx data", ADDR_RX_DATA, 8'h3C);
      w(ADDR_EVT_CLR, 8'h01);
      check("evt cleared", {7'h0, evt_irq_o}, ZERO8);
      w(ADDR_EVT_EN, ZERO8);
      rx(8'h11);
      check("evt masked", {7'h0, evt_irq_o}, ZERO8);
      rc("evt status", ADDR_EVT_STAT, 8'h01);
      rc("rx data", ADDR_RX_DATA, 8'h11);
      // overrun, short stop bit, status clear, line status writes
      for (n = 0; n < 5; n++) u_mod.send(8'h20 + n[7:0], (n == 1) ? 12 : 16);
      tick(4);
      rc("full", ADDR_LEVEL, 8'(BUF_DEPTH));
      acc(1'b1, 1'b0, ADDR_LSTAT, ZERO8);
      check("overrun", {7'h0, d[LSTAT_OVR_BIT]}, 8'h01);
      rc("first", ADDR_RX_DATA, 8'h20);
      rc("after short stop", ADDR_RX_DATA, 8'h21);
      w(ADDR_ICMD, 8'(1 << ICMD_STATUS_CLR));
      acc(1'b1, 1'b0, ADDR_LSTAT, ZERO8);
      check("status clear", {6'h0, d[1:0]}, 8'h01);
      w(ADDR_LSTAT, 8'h1E);
      rc("emptied", ADDR_LEVEL, ZERO8);
      acc(1'b1, 1'b0, ADDR_LSTAT, ZERO8);
      check("lstat set", {3'h0, d[4:0]}, 8'h1E);
      rx(8'h66);
      w(ADDR_LSTAT, 8'h1D);
      acc(1'b1, 1'b0, ADDR_LSTAT, ZERO8);
      check("lstat reset", {3'h0, d[4:0]}, 8'h1D);
      rc("kept", ADDR_RX_DATA, 8'h66);
      $display("end of status tests");
      // receive commands
      rx(8'h44);
      w(ADDR_RCMD, 8'h90);
      rc("flushed", ADDR_LEVEL, ZERO8);
      w(ADDR_RCMD, 8'h88);
      rx(8'h45);
      rc("locked", ADDR_LEVEL, ZERO8);
      w(ADDR_RCMD, 8'hB8);
      rx(8'h77);
      rc("unlocked", ADDR_LEVEL, 8'h01);
      rc("combined", ADDR_RX_DATA, 8'h77);
      // address gating
      w(ADDR_RMODE, {6'h0, RMODE_SEMI});
      rx(8'h81);
      rc("semi", ADDR_LEVEL, 8'h01);
      w(ADDR_RCMD, 8'h90);
      w(ADDR_RMODE, {6'h0, RMODE_AUTO});
      rx(8'h82);
      rc("no match", ADDR_LEVEL, ZERO8);
      rx(8'h85);
      rx(8'hA5);
      rc("match", ADDR_LEVEL, 8'h02);
      // auto-acknowledge on a data read
      w(ADDR_RCMD, 8'h90);
      w(ADDR_RMODE, 8'(1 << RMODE_AUTOACK));
      w(ADDR_IEN, 8'(1 << IEN_RX_BIT));
      rx(8'h12);
      rx(8'h13);
      check("irq", {7'h0, irq_o}, 8'h01);
      rc("ack read", ADDR_RX_DATA, 8'h12);
      check("irq acked", {7'h0, irq_o}, ZERO8);
      $display("end of receive tests");
      // semi and automatic transmit; manual mode between frees the pin
      w(ADDR_IEN, 8'h02);
      rc("ident", ADDR_IIDENT, 8'h02);
      check("held", {7'h0, irq_o}, ZERO8);
      w(ADDR_IEN, ZERO8);
      w(ADDR_IEN, 8'h02);
      check("freed", {7'h0, irq_o}, 8'h01);
      for (int m = 1; m < 3; m++) begin
         w(ADDR_TMODE, 8'(m));
         w(ADDR_TX_DATA, 8'hC3 ^ 8'(m));
         txcap(n, d);
         check("rts lead", n[7:0], 8'h10);
         check("tx byte", d, 8'hC3 ^ 8'(m));
         tick(40);
         w(ADDR_TMODE, ZERO8);
      end
      // external transmit clock, then input divide by two: one tick every two cycles
      w(ADDR_PINMODE, 8'(1 << PINMODE_SCLK));
      sclk_on <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         w(ADDR_CLKCFG, c ? 8'h01 : CLKCFG_EXT_TX);
         w(ADDR_TX_DATA, 8'hA5);
         for (n = 0; n < 400 && txd_o === 1'b1; n++) tick(1);
         for (n = 0; n < 100 && txd_o === 1'b0; n++) tick(1);
         check("slow bit", {7'h0, n > 29 && n < 35}, 8'h01);
         tick(300);
      end
      sclk_on <= 1'b0;
      $display("end of transmit tests");
      // second reset in mid-run
      @(posedge core_clk_i);
      nrst_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      rc("rst divisor", ADDR_DIVISOR, DIVISOR_RST);
      rc("rst level", ADDR_LEVEL, ZERO8);
      check("rst lines", {6'h0, txd_o, rts_n_o}, 8'h03);
      $display("end of reset test");
      summarize();
   end
endmodule : asc_top_bench
